// >>> include/mwe_map.svh
// Purpose: offsets, field positions and reset values of the window detector registers
// Assumes: word-aligned AHB-Lite access, byte address = index * 4
// Notes: indexes are 6 bits wide, the low two address bits must be zero
`ifndef MWE_MAP_SVH
`define MWE_MAP_SVH

`define MWE_IDX_SRC_OUT 6'h2D
`define MWE_IDX_SRC_IN 6'h2E
`define MWE_IDX_AXIS_CFG 6'h2F
`define MWE_IDX_CTRL 6'h30
`define MWE_IDX_DBC_OUT 6'h31
`define MWE_IDX_DBC_IN 6'h32
`define MWE_IDX_IRQ_STAT 6'h33
`define MWE_IDX_IRQ_MASK 6'h34

`define MWE_AX_OUT_LATCH 7
`define MWE_AX_IN_LATCH 6
`define MWE_AX_OUT_HI 5
`define MWE_AX_OUT_LO 3
`define MWE_AX_IN_HI 2
`define MWE_AX_IN_LO 0

`define MWE_CT_DET_EN 7
`define MWE_CT_REF_HI 6
`define MWE_CT_REF_LO 5
`define MWE_CT_OUT_DBC 4
`define MWE_CT_IN_DBC 3
`define MWE_CT_IN_LOGIC 2
`define MWE_CT_MODE 1
`define MWE_CT_REF_STROBE 0

`define MWE_AXIS_RST_GND 8'h00
`define MWE_AXIS_RST_VDD 8'h38
`define MWE_CTRL_RST_GND 8'h00
`define MWE_CTRL_RST_VDD 8'hD8
`define MWE_REF_ZERO 2'h3
`define MWE_HSIZE_WORD 3'h2

`endif

// >>> include/mwe_pkg.sv
// Purpose: shared types of the window detector configuration block
// Assumes: nothing beyond the map header
// Notes: boot sequence states only
`default_nettype none
package mwe_pkg;
  typedef enum logic [1:0] {
    MWE_ST_SYNC,
    MWE_ST_SETTLE,
    MWE_ST_LOAD,
    MWE_ST_RUN
  } mwe_boot_state_t;
endpackage : mwe_pkg
`default_nettype wire

// >>> include/mwe_win_if.sv
// Purpose: configuration and result bundle between the register bank and one window
// Assumes: single clock domain
// Notes: ctl side is the register bank, win side the event logic
`timescale 1ns/1ps
`default_nettype none
interface mwe_win_if #(parameter int DBC_W = 8);
  logic run;
  logic tick;
  logic latch_en;
  logic clear_mode;
  logic and_sel;
  logic clr;
  logic [2:0] axis_en;
  logic [2:0] axis_hit;
  logic [DBC_W-1:0] dbc_count;
  logic ea;
  logic rise;
  logic [2:0] flags;
  modport ctl (output run, tick, latch_en, clear_mode, and_sel, clr, axis_en, axis_hit,
    dbc_count, input ea, rise, flags);
  modport win (input run, tick, latch_en, clear_mode, and_sel, clr, axis_en, axis_hit,
    dbc_count, output ea, rise, flags);
endinterface : mwe_win_if
`default_nettype wire

// >>> logic/mwe_window_config.sv
// Purpose: AHB-Lite register bank of the motion window detector with event interrupt
// Assumes: one 10 MHz clock, condition inputs and tick come from same-clock logic
// Notes: zero wait states; read data registered in the address phase
`timescale 1ns/1ps
`default_nettype none
`include "mwe_map.svh"
module mwe_window_config
  import mwe_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DBC_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic boot_strap_pin,
  input wire logic odr_tick,
  input wire logic [2:0] outside_axis_hit,
  input wire logic [2:0] inside_axis_hit,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic detector_clk_en,
  output logic [1:0] reference_update_mode,
  output logic ref_zero,
  output logic ref_update_pulse,
  output logic mode_select,
  output logic outside_event_active,
  output logic inside_event_active
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic mwe_hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction : mwe_hit

  // source layout: event in bit 7, x/y/z flags in bits 5/3/1
  function automatic logic [7:0] mwe_src(input logic ea, input logic [2:0] f);
    return {ea, 1'b0, f[2], 1'b0, f[1], 1'b0, f[0], 1'b0};
  endfunction : mwe_src

  mwe_win_if #(.DBC_W(DBC_W)) out_if ();
  mwe_win_if #(.DBC_W(DBC_W)) in_if ();

  logic [1:0] strap_sync;
  mwe_boot_state_t boot_state;
  logic [7:0] axis_cfg;
  logic [7:0] ctrl;
  logic [DBC_W-1:0] out_dbc;
  logic [DBC_W-1:0] in_dbc;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [1:0] next_irq_stat;
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // boot strap capture
  // ----------------------------------------------------------------
  // the strap is a pin, so it is only read behind two flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_sync <= 2'b00;
    end else begin
      strap_sync <= {strap_sync[0], boot_strap_pin};
    end
  end

  // strap defaults are loaded after the synchroniser has settled; reset itself loads the ground-strap values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_state <= MWE_ST_SYNC;
    end else begin
      case (boot_state)
        MWE_ST_SYNC: boot_state <= MWE_ST_SETTLE;
        MWE_ST_SETTLE: boot_state <= MWE_ST_LOAD;
        MWE_ST_LOAD: boot_state <= MWE_ST_RUN;
        MWE_ST_RUN: begin
          if (soft_rst) begin
            boot_state <= MWE_ST_LOAD;
          end
        end
        default: boot_state <= MWE_ST_SYNC;
      endcase
    end
  end

  wire loading = (boot_state == MWE_ST_LOAD);
  wire bus_open = (boot_state == MWE_ST_RUN) && !soft_rst;
  wire strap_high = strap_sync[1];

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  wire addr_ok = hsel && htrans[1] && hready;
  wire wr_take = addr_ok && hwrite && (hsize == `MWE_HSIZE_WORD);
  wire rd_take = addr_ok && !hwrite;
  wire wr_now = wr_pend && bus_open;

  wire wr_axis = wr_now && mwe_hit(wr_addr, `MWE_IDX_AXIS_CFG);
  wire wr_ctrl = wr_now && mwe_hit(wr_addr, `MWE_IDX_CTRL);
  wire wr_dbc_out = wr_now && mwe_hit(wr_addr, `MWE_IDX_DBC_OUT);
  wire wr_dbc_in = wr_now && mwe_hit(wr_addr, `MWE_IDX_DBC_IN);
  wire wr_stat = wr_now && mwe_hit(wr_addr, `MWE_IDX_IRQ_STAT);
  wire wr_mask = wr_now && mwe_hit(wr_addr, `MWE_IDX_IRQ_MASK);

  wire rd_src_out = rd_take && mwe_hit(haddr, `MWE_IDX_SRC_OUT);
  wire rd_src_in = rd_take && mwe_hit(haddr, `MWE_IDX_SRC_IN);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (mwe_hit(haddr, `MWE_IDX_SRC_OUT)) begin
      rd_mux = {24'h00_0000, mwe_src(out_if.ea, out_if.flags)};
    end else if (mwe_hit(haddr, `MWE_IDX_SRC_IN)) begin
      rd_mux = {24'h00_0000, mwe_src(in_if.ea, in_if.flags)};
    end else if (mwe_hit(haddr, `MWE_IDX_AXIS_CFG)) begin
      rd_mux = {24'h00_0000, axis_cfg};
    end else if (mwe_hit(haddr, `MWE_IDX_CTRL)) begin
      rd_mux = {24'h00_0000, ctrl};
    end else if (mwe_hit(haddr, `MWE_IDX_DBC_OUT)) begin
      rd_mux = 32'(out_dbc);
    end else if (mwe_hit(haddr, `MWE_IDX_DBC_IN)) begin
      rd_mux = 32'(in_dbc);
    end else if (mwe_hit(haddr, `MWE_IDX_IRQ_STAT)) begin
      rd_mux = {30'h0, irq_stat};
    end else if (mwe_hit(haddr, `MWE_IDX_IRQ_MASK)) begin
      rd_mux = {30'h0, irq_mask};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= wr_take;
      wr_addr <= haddr;
      hrdata <= rd_take ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      axis_cfg <= `MWE_AXIS_RST_GND;
      ctrl <= `MWE_CTRL_RST_GND;
    end else if (loading) begin
      axis_cfg <= strap_high ? `MWE_AXIS_RST_VDD : `MWE_AXIS_RST_GND;
      ctrl <= strap_high ? `MWE_CTRL_RST_VDD : `MWE_CTRL_RST_GND;
    end else begin
      if (wr_axis) begin
        axis_cfg <= hwdata[7:0];
      end
      if (wr_ctrl) begin
        ctrl <= {hwdata[7:1], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_dbc <= '0;
      in_dbc <= '0;
      irq_mask <= 2'h0;
    end else begin
      if (wr_dbc_out) begin
        out_dbc <= hwdata[DBC_W-1:0];
      end
      if (wr_dbc_in) begin
        in_dbc <= hwdata[DBC_W-1:0];
      end
      if (wr_mask) begin
        irq_mask <= hwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // the reference strobe is one-shot, so it never reads back as one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      detector_clk_en <= 1'b0;
      reference_update_mode <= 2'h0;
      ref_zero <= 1'b0;
      ref_update_pulse <= 1'b0;
      mode_select <= 1'b0;
    end else begin
      detector_clk_en <= ctrl[`MWE_CT_DET_EN];
      reference_update_mode <= ctrl[`MWE_CT_REF_HI:`MWE_CT_REF_LO];
      ref_zero <= ctrl[`MWE_CT_REF_HI:`MWE_CT_REF_LO] == `MWE_REF_ZERO;
      ref_update_pulse <= wr_ctrl && hwdata[`MWE_CT_REF_STROBE];
      mode_select <= ctrl[`MWE_CT_MODE];
    end
  end

  // ----------------------------------------------------------------
  // window event logic
  // ----------------------------------------------------------------
  assign out_if.run = ctrl[`MWE_CT_DET_EN];
  assign out_if.tick = odr_tick;
  assign out_if.latch_en = axis_cfg[`MWE_AX_OUT_LATCH];
  assign out_if.axis_en = axis_cfg[`MWE_AX_OUT_HI:`MWE_AX_OUT_LO];
  assign out_if.axis_hit = outside_axis_hit;
  assign out_if.clear_mode = ctrl[`MWE_CT_OUT_DBC];
  assign out_if.and_sel = 1'b0;
  assign out_if.dbc_count = out_dbc;
  assign out_if.clr = rd_src_out;

  assign in_if.run = ctrl[`MWE_CT_DET_EN];
  assign in_if.tick = odr_tick;
  assign in_if.latch_en = axis_cfg[`MWE_AX_IN_LATCH];
  assign in_if.axis_en = axis_cfg[`MWE_AX_IN_HI:`MWE_AX_IN_LO];
  assign in_if.axis_hit = inside_axis_hit;
  assign in_if.clear_mode = ctrl[`MWE_CT_IN_DBC];
  assign in_if.and_sel = ctrl[`MWE_CT_IN_LOGIC];
  assign in_if.dbc_count = in_dbc;
  assign in_if.clr = rd_src_in;

  mwe_window_event #(.DBC_W(DBC_W)) u_outside (
    .clk(clk),
    .rst(rst),
    .w(out_if.win)
  );

  mwe_window_event #(.DBC_W(DBC_W)) u_inside (
    .clk(clk),
    .rst(rst),
    .w(in_if.win)
  );

  assign outside_event_active = out_if.ea;
  assign inside_event_active = in_if.ea;

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // a new event on the clearing write's edge survives the clear
  assign next_irq_stat = (irq_stat & ~(wr_stat ? hwdata[1:0] : 2'h0)) |
    {in_if.rise, out_if.rise};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_out_read_clears;
    rd_src_out && out_if.latch_en && out_if.run && !(odr_tick && out_if.axis_en != 3'h0)
      |=> !out_if.ea && out_if.flags == 3'h0;
  endproperty
  a_out_read_clears: assert property (p_out_read_clears) else $error("outside read no clear");

  property p_out_latch_holds;
    out_if.latch_en && out_if.ea && !rd_src_out && out_if.run
      ##1 out_if.latch_en && out_if.run |-> out_if.ea;
  endproperty
  a_out_latch_holds: assert property (p_out_latch_holds) else $error("outside latch lost");

  property p_in_read_clears;
    rd_src_in && in_if.latch_en && in_if.run && !(odr_tick && in_if.axis_en != 3'h0)
      |=> !in_if.ea && in_if.flags == 3'h0;
  endproperty
  a_in_read_clears: assert property (p_in_read_clears) else $error("inside read no clear");

  property p_det_off;
    !ctrl[`MWE_CT_DET_EN] |=> !detector_clk_en && !out_if.ea && !in_if.ea;
  endproperty
  a_det_off: assert property (p_det_off) else $error("detector active while disabled");

  property p_ref_zero;
    ctrl[`MWE_CT_REF_HI:`MWE_CT_REF_LO] == `MWE_REF_ZERO |=> ref_zero;
  endproperty
  a_ref_zero: assert property (p_ref_zero) else $error("zero reference not selected");

  property p_strap_load;
    loading |=> axis_cfg == ($past(strap_high) ? `MWE_AXIS_RST_VDD : `MWE_AXIS_RST_GND)
      && ctrl == ($past(strap_high) ? `MWE_CTRL_RST_VDD : `MWE_CTRL_RST_GND);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("wrong strap defaults");

  property p_axis_write;
    wr_axis |=> axis_cfg == $past(hwdata[7:0]);
  endproperty
  a_axis_write: assert property (p_axis_write) else $error("axis config not written");

  property p_ctrl_write;
    wr_ctrl |=> ctrl == {$past(hwdata[7:1]), 1'b0} && ref_update_pulse == $past(hwdata[0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control not written");

  property p_irq_level;
    ##1 irq == |($past(next_irq_stat) & $past(irq_mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready okay");

  c_out_event: cover property (out_if.rise ##[1:50] rd_src_out);
  c_in_event: cover property (in_if.rise && in_if.latch_en);
  c_irq: cover property ($rose(irq) ##[1:50] wr_stat);
  c_strap_vdd: cover property (loading && strap_high);
endmodule : mwe_window_config
`default_nettype wire

// >>> logic/mwe_window_event.sv
// Purpose: debounce, event-active and per-axis flag logic of one window condition
// Assumes: tick is a one-cycle pulse per output data period
// Notes: a set on the same edge as a read-clear wins
`timescale 1ns/1ps
`default_nettype none
module mwe_window_event #(
  parameter int DBC_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  mwe_win_if.win w
);
  logic [2:0] masked;
  logic cond;
  logic hit;
  logic fresh;
  logic eval;
  logic prev_hit;
  logic [DBC_W-1:0] cnt;
  logic [DBC_W-1:0] next_cnt;
  logic next_ea;
  logic [2:0] next_flags;

  assign masked = w.axis_hit & w.axis_en;
  assign cond = (w.axis_en != 3'h0) &&
    (w.and_sel ? (masked == w.axis_en) : (masked != 3'h0));
  assign hit = cond && (cnt >= w.dbc_count);
  assign fresh = hit && !prev_hit;
  assign eval = w.run && w.tick;

  always_comb begin
    if (cond) begin
      next_cnt = (cnt < w.dbc_count) ? cnt + 1'b1 : cnt;
    end else if (w.clear_mode || cnt == '0) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_comb begin
    next_ea = w.ea;
    next_flags = w.flags;
    if (!w.run) begin
      next_ea = 1'b0;
      next_flags = 3'h0;
    end else if (w.latch_en) begin
      if (w.clr) begin
        next_ea = 1'b0;
        next_flags = 3'h0;
      end
      if (eval && fresh) begin
        next_ea = 1'b1;
        next_flags = (w.clr ? 3'h0 : w.flags) | masked;
      end
    end else if (eval) begin
      next_ea = hit;
      next_flags = (hit || w.dbc_count == '0) ? masked : 3'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      prev_hit <= 1'b0;
    end else if (!w.run) begin
      cnt <= '0;
      prev_hit <= 1'b0;
    end else if (w.tick) begin
      cnt <= next_cnt;
      prev_hit <= hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w.ea <= 1'b0;
      w.flags <= 3'h0;
      w.rise <= 1'b0;
    end else begin
      w.ea <= next_ea;
      w.flags <= next_flags;
      w.rise <= next_ea && !w.ea;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_edge_only;
    w.run && w.latch_en && w.tick && hit && prev_hit && !w.ea && !w.clr |=> !w.ea;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("latched event set without edge");

  property p_realtime;
    w.run && !w.latch_en && w.tick |=> w.ea == $past(hit);
  endproperty
  a_realtime: assert property (p_realtime) else $error("unlatched event not updated");

  property p_axis_mask;
    w.run && w.tick |=> (w.flags & ~$past(w.axis_en)) == 3'h0 || $past(w.latch_en);
  endproperty
  a_axis_mask: assert property (p_axis_mask) else $error("disabled axis reached a flag");

  property p_none_enabled;
    w.axis_en == 3'h0 |-> !hit;
  endproperty
  a_none_enabled: assert property (p_none_enabled) else $error("condition true with no axis");

  property p_debounce;
    w.run && w.tick && w.dbc_count != '0 && cnt < w.dbc_count |-> !hit;
  endproperty
  a_debounce: assert property (p_debounce) else $error("event before debounce count");

  property p_clear_mode;
    w.run && w.tick && !cond && w.clear_mode |=> cnt == '0;
  endproperty
  a_clear_mode: assert property (p_clear_mode) else $error("counter not cleared");

  c_latched_event: cover property (w.latch_en && w.rise ##[1:20] w.clr);
endmodule : mwe_window_event
`default_nettype wire

// >>> tb/mwe_host_model.sv
// Purpose: host processor side, an AHB-Lite master for the window detector registers
// Assumes: one slave whose hreadyout is the bus hready, single word transfers
// Notes: tmo counts waits that ran out of their bound
`timescale 1ns/1ps
`default_nettype none
module mwe_host_model (
  input wire logic clk,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  int tmo = 0;
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ---------------------------------------
  // bus cycles
  // ---------------------------------------
  // bounded so that a dead slave ends the run instead of hanging it
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) tmo++;
  endtask : wait_rdy
  // caller sits just after a rising edge
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
endmodule : mwe_host_model
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench of the window detector register bank
// Assumes: strap and hits are driven here, host model runs the bus
// Notes: debounce counts are zeroed before the first event test and set to 2 for the debounce tests
`timescale 1ns/1ps
`default_nettype none
`include "mwe_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
  localparam logic [5:0] ax = `MWE_IDX_AXIS_CFG;
  localparam logic [5:0] ct = `MWE_IDX_CTRL;
  localparam logic [5:0] so = `MWE_IDX_SRC_OUT;
  localparam logic [5:0] si = `MWE_IDX_SRC_IN;
  localparam logic [5:0] st = `MWE_IDX_IRQ_STAT;
  localparam logic [5:0] mk = `MWE_IDX_IRQ_MASK;
  int fails = 0;
  int checked = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  logic strap = 1'b1;
  logic odr_tick = 1'b0;
  logic [2:0] oh = 3'h0;
  logic [2:0] ih = 3'h0;
  logic hsel, hwrite, hreadyout, hresp, irq, clk_en, ref_zero, mode_sel, oea, iea, ref_pulse;
  logic [7:0] haddr;
  logic [1:0] htrans, ref_mode;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  always #50 clk = ~clk;
  mwe_window_config mwe_window_config_inst (.clk(clk), .rst(rst), .soft_rst(soft_rst),
    .boot_strap_pin(strap), .odr_tick(odr_tick), .outside_axis_hit(oh),
    .inside_axis_hit(ih), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .detector_clk_en(clk_en),
    .reference_update_mode(ref_mode), .ref_zero(ref_zero), .ref_update_pulse(ref_pulse),
    .mode_select(mode_sel), .outside_event_active(oea), .inside_event_active(iea));
  mwe_host_model mwe_host_model_inst (.clk(clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  // ---------------------------------------
  // tasks
  // ---------------------------------------
  task automatic print_verdict();
    fails += mwe_host_model_inst.tmo;
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    mwe_host_model_inst.xfer(1'b1, idx, {24'h0, d}, r);
    if (mwe_host_model_inst.tmo != 0) print_verdict();
    // results of the write launch on the data phase edge, let them settle
    @(posedge clk);
  endtask : wr
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] r;
    mwe_host_model_inst.xfer(1'b0, idx, 32'h0, r);
    if (mwe_host_model_inst.tmo != 0) print_verdict();
    `CHK(r, {24'h0, e})
  endtask : rd_chk
  // one output-data period with the given comparator results
  task automatic tk(input logic [2:0] o, input logic [2:0] i);
    oh <= o;
    ih <= i;
    odr_tick <= 1'b1;
    @(posedge clk);
    odr_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : tk
  // ---------------------------------------
  // sequence
  // ---------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(ax, 8'h38);
    rd_chk(ct, 8'hD8);
    `CHK(clk_en, 1'b1)
    `CHK(ref_mode, 2'h2)
    `CHK(hresp, 1'b0)
    rd_chk(6'h3F, 8'h00);
    wr(ax, 8'h55);
    rd_chk(ax, 8'h55);
    wr(ax, 8'hAA);
    rd_chk(ax, 8'hAA);
    wr(ct, 8'h67);
    `CHK(ref_pulse, 1'b1)
    rd_chk(ct, 8'h66);
    `CHK({ref_zero, mode_sel}, 2'h3)
    strap <= 1'b0;
    repeat (3) @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(ax, 8'h00);
    rd_chk(ct, 8'h00);
    wr(`MWE_IDX_DBC_OUT, 8'h00);
    wr(`MWE_IDX_DBC_IN, 8'h00);
    wr(mk, 8'h01);
    wr(ct, 8'h98);
    wr(ax, 8'hA0);
    tk(3'h2, 3'h0);
    `CHK(oea, 1'b0)
    tk(3'h4, 3'h0);
    `CHK({oea, irq}, 2'h3)
    tk(3'h0, 3'h0);
    `CHK(oea, 1'b1)
    rd_chk(so, 8'hA0);
    `CHK(oea, 1'b0)
    tk(3'h4, 3'h0);
    rd_chk(so, 8'hA0);
    tk(3'h4, 3'h0);
    `CHK(oea, 1'b0)
    wr(st, 8'h01);
    `CHK(irq, 1'b0)
    wr(mk, 8'h02);
    tk(3'h0, 3'h0);
    tk(3'h4, 3'h0);
    `CHK({oea, irq}, 2'h2)
    rd_chk(st, 8'h01);
    wr(st, 8'h01);
    wr(ax, 8'h38);
    tk(3'h1, 3'h0);
    rd_chk(so, 8'h82);
    tk(3'h0, 3'h0);
    `CHK(oea, 1'b0)
    wr(ax, 8'h80);
    tk(3'h7, 3'h0);
    `CHK(oea, 1'b0)
    wr(ax, 8'h46);
    wr(ct, 8'h9C);
    `CHK(ref_pulse, 1'b0)
    tk(3'h0, 3'h4);
    `CHK(iea, 1'b0)
    tk(3'h0, 3'h6);
    `CHK({iea, irq}, 2'h3)
    tk(3'h0, 3'h0);
    `CHK(iea, 1'b1)
    rd_chk(si, 8'hA8);
    `CHK(iea, 1'b0)
    tk(3'h0, 3'h6);
    rd_chk(si, 8'hA8);
    tk(3'h0, 3'h6);
    `CHK(iea, 1'b0)
    wr(st, 8'h03);
    `CHK(irq, 1'b0)
    // and logic with no axis must not count as all axes true
    wr(ax, 8'h00);
    tk(3'h0, 3'h7);
    `CHK(iea, 1'b0)
    wr(ax, 8'h01);
    wr(ct, 8'h98);
    tk(3'h0, 3'h1);
    rd_chk(si, 8'h82);
    tk(3'h0, 3'h0);
    `CHK(iea, 1'b0)
    wr(ct, 8'h18);
    tk(3'h0, 3'h1);
    `CHK({iea, clk_en}, 2'h0)
    wr(`MWE_IDX_DBC_IN, 8'h02);
    wr(ct, 8'h98);
    tk(3'h0, 3'h1);
    tk(3'h0, 3'h1);
    `CHK(iea, 1'b0)
    tk(3'h0, 3'h1);
    `CHK(iea, 1'b1)
    wr(ax, 8'h20);
    wr(`MWE_IDX_DBC_OUT, 8'h02);
    for (int m = 0; m < 2; m++) begin
      wr(ct, m[0] ? 8'h18 : 8'h08);
      wr(ct, m[0] ? 8'h98 : 8'h88);
      tk(3'h4, 3'h0);
      tk(3'h4, 3'h0);
      tk(3'h0, 3'h0);
      tk(3'h4, 3'h0);
      tk(3'h4, 3'h0);
      `CHK(oea, (m == 0))
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
